/* File: bench/host_model.sv */
// Host side model issuing command bytes and RAM accesses.
`timescale 1ns/1ps
module host_model (
	input wire clock,
	input wire pump_ready,
	output reg cmd_valid,
	output reg cmd_rw,
	output reg [1:0] cmd_rs,
	output reg [7:0] cmd_data,
	output reg ram_step
);
	initial begin
		cmd_valid = 1'b0;
		cmd_rw = 1'b0;
		cmd_rs = 2'h0;
		cmd_data = 8'h00;
		ram_step = 1'b0;
	end
	// =====
	// Command byte
	// read flag taken from rw (high reads, low writes)
	// Idle rs and data show the inverse so a stale byte is never mistaken for a new one.
	task send(input [1:0] rs, input [7:0] d, input rw);
		begin
			@(posedge clock);
			cmd_valid <= 1'b1;
			cmd_rw <= rw;
			cmd_rs <= rs;
			cmd_data <= d;
			@(posedge clock);
			cmd_valid <= 1'b0;
			cmd_rs <= ~rs;
			cmd_data <= ~d;
		end
	endtask
	// =====
	// Bring-up
	// RAM then pump first
	task bring_up(input integer words);
		integer i;
		begin
			for (i = 0; i < words; i = i + 1) begin
				@(posedge clock);
				ram_step <= 1'b1;
				@(posedge clock);
				ram_step <= 1'b0;
			end
			send(2'h3, 8'h84, 1'b0);
			for (i = 0; i < 50 && pump_ready !== 1'b1; i = i + 1)
				@(posedge clock);
			if (pump_ready === 1'b1)
				send(2'h2, 8'h24, 1'b0);
		end
	endtask
endmodule

/* File: bench/lcd_tc_monitor.sv */
// Port checker for the temperature and start-up control block.
`timescale 1ns/1ps
module lcd_tc_monitor (
	input wire clock,
	input wire rst_b,
	input wire reset_pin_b,
	input wire power_down_pin,
	input wire cmd_valid,
	input wire [1:0] cmd_rs,
	input wire [7:0] cmd_data,
	input wire cmd_accept,
	input wire init_pending,
	input wire temp_sample_valid,
	input wire [7:0] temp_sample,
	input wire temp_rd_req,
	input wire comp_enable,
	input wire filter_enable,
	input wire measure_enable,
	input wire [2:0] slope_a_coeff,
	input wire [2:0] slope_d_coeff,
	input wire [7:0] temperature_value,
	input wire temp_rd_valid,
	input wire temp_rd_refused,
	input wire [4:0] frame_freq,
	input wire display_on,
	input wire pump_enable,
	input wire [11:0] ram_addr,
	input wire drivers_ground,
	input wire mux_1_18,
	input wire circuits_on
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	wire is_init = cmd_rs == 2'h1 && cmd_data == 8'h3A;
	wire wr3 = cmd_accept && cmd_rs == 2'h3;
	// =====
	// Properties
	a_init_first: assert property (init_pending && cmd_valid && !is_init |-> !cmd_accept)
		else $error("command taken before initialise");
	a_init_clear: assert property (cmd_accept && is_init |=>
		!measure_enable && !filter_enable && !comp_enable && !pump_enable && !display_on
		&& ram_addr == 12'h000) else $error("initialise left a setting on");
	a_init_ground: assert property (cmd_accept && is_init |=> drivers_ground && mux_1_18)
		else $error("initialise did not ground drivers");
	a_temp_ctrl: assert property (wr3 && cmd_data[7:3] == 5'h00 |=>
		{comp_enable, filter_enable, measure_enable} == $past(cmd_data[2:0]))
		else $error("temperature control bits wrong");
	a_slope_first: assert property (wr3 && cmd_data[7:3] == 5'h01 |=>
		slope_a_coeff == $past(cmd_data[2:0])) else $error("first slope wrong");
	a_slope_last: assert property (wr3 && cmd_data[7:3] == 5'h04 |=>
		slope_d_coeff == $past(cmd_data[2:0])) else $error("last slope wrong");
	a_raw_pass: assert property (temp_sample_valid && measure_enable && !filter_enable
		&& circuits_on && !cmd_accept |=> temperature_value == $past(temp_sample))
		else $error("raw sample not passed through");
	a_rd_refuse: assert property (temp_rd_req && !measure_enable |=>
		temp_rd_refused && !temp_rd_valid) else $error("readout not refused");
	a_pd_off: assert property (power_down_pin [*3] |->
		!circuits_on && drivers_ground && !cmd_accept) else $error("power down ignored");
	a_pin_reset: assert property (!reset_pin_b [*4] |-> init_pending
		&& !measure_enable && slope_a_coeff == 3'h0 && frame_freq == 5'h07)
		else $error("pin reset left a setting");
	c_init: cover property (cmd_accept && is_init);
	c_temp: cover property (wr3 && cmd_data[7:3] == 5'h00);
	c_pd: cover property (!circuits_on);
endmodule
bind lcd_temp_comp_ctrl_and_init lcd_tc_monitor mon (.clock, .rst_b, .reset_pin_b,
	.power_down_pin, .cmd_valid, .cmd_rs, .cmd_data, .cmd_accept, .init_pending,
	.temp_sample_valid, .temp_sample, .temp_rd_req, .comp_enable, .filter_enable,
	.measure_enable, .slope_a_coeff, .slope_d_coeff, .temperature_value, .temp_rd_valid,
	.temp_rd_refused, .frame_freq, .display_on, .pump_enable, .ram_addr, .drivers_ground,
	.mux_1_18, .circuits_on);

/* File: bench/lcd_temp_comp_ctrl_and_init_tb.sv */
// Self-checking bench for the temperature and start-up control block.
`timescale 1ns/1ps
module lcd_temp_comp_ctrl_and_init_tb;
	reg clock, rst_b, reset_pin_b, power_down_pin, temp_sample_valid, temp_rd_req, pump_ready;
	reg [7:0] temp_sample;
	wire cmd_valid, cmd_rw, ram_step, init_pending, host_may_transfer, comp_enable;
	wire filter_enable, measure_enable, temp_rd_valid, temp_rd_refused, drivers_ground;
	wire mux_1_18, addr_increment, display_on, pump_enable, pump_run, circuits_on;
	wire comp_active, segment_reverse;
	wire [1:0] cmd_rs, pump_mult;
	wire [2:0] slope_a_coeff, slope_b_coeff, slope_c_coeff, slope_d_coeff, inversion_mode;
	wire [8:0] vlcd_value;
	wire [7:0] cmd_data, temperature_value, comp_temperature;
	wire [4:0] frame_freq;
	wire [11:0] ram_addr;
	integer err_count = 0;
	integer tests_run = 0;
	integer i;
	always #25 clock = ~clock;
	host_model h (.clock(clock), .pump_ready(pump_ready), .cmd_valid(cmd_valid),
		.cmd_rw(cmd_rw), .cmd_rs(cmd_rs), .cmd_data(cmd_data), .ram_step(ram_step));
	// A short power-on wait keeps the run brief.
	lcd_temp_comp_ctrl_and_init #(.POWERON_CYCLES(20)) dut (.clock(clock), .rst_b(rst_b),
		.reset_pin_b(reset_pin_b), .power_down_pin(power_down_pin), .cmd_valid(cmd_valid),
		.cmd_rw(cmd_rw), .cmd_rs(cmd_rs), .cmd_data(cmd_data), .ram_step(ram_step),
		.temp_sample_valid(temp_sample_valid), .temp_sample(temp_sample),
		.temp_rd_req(temp_rd_req), .pump_ready(pump_ready), .cmd_accept(),
		.init_pending(init_pending), .host_may_transfer(host_may_transfer),
		.comp_enable(comp_enable), .filter_enable(filter_enable),
		.measure_enable(measure_enable), .slope_a_coeff(slope_a_coeff),
		.slope_b_coeff(slope_b_coeff), .slope_c_coeff(slope_c_coeff),
		.slope_d_coeff(slope_d_coeff), .temperature_value(temperature_value),
		.temp_rd_valid(temp_rd_valid), .temp_rd_refused(temp_rd_refused),
		.comp_temperature(comp_temperature), .comp_active(comp_active),
		.drivers_ground(drivers_ground), .mux_1_18(mux_1_18), .ram_addr(ram_addr),
		.addr_increment(addr_increment), .inversion_mode(inversion_mode),
		.frame_freq(frame_freq), .display_on(display_on), .segment_reverse(segment_reverse),
		.pump_enable(pump_enable), .pump_mult(pump_mult), .vlcd_value(vlcd_value),
		.pump_run(pump_run), .circuits_on(circuits_on));
	// =====
	// Helpers
	task chk(input [15:0] got, input [15:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("[FAIL] %0t got %h want %h", $time, got, exp);
			end
		end
	endtask
	task tend(input integer n);
		$display("test %0d done, mismatches %0d", n, err_count);
	endtask
	task smp(input [7:0] v);
		begin
			@(posedge clock);
			temp_sample_valid <= 1'b1;
			temp_sample <= v;
			@(posedge clock);
			temp_sample_valid <= 1'b0;
			temp_sample <= ~v;
			#1;
		end
	endtask
	task rd;
		begin
			@(posedge clock);
			temp_rd_req <= 1'b1;
			@(posedge clock);
			temp_rd_req <= 1'b0;
			#1;
		end
	endtask
	task pins(input rb, input pd);
		begin
			@(posedge clock);
			reset_pin_b <= rb;
			power_down_pin <= pd;
			repeat (4) @(posedge clock);
			#1;
		end
	endtask
	task stop_test;
		begin
			$display("checks %0d mismatches %0d", tests_run, err_count);
			if (err_count == 0 && tests_run > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	// =====
	// Sequence
	initial begin
		clock = 1'b0;
		rst_b = 1'b0;
		reset_pin_b = 1'b1;
		power_down_pin = 1'b0;
		temp_sample_valid = 1'b0;
		temp_rd_req = 1'b0;
		temp_sample = 8'h00;
		pump_ready = 1'b0;
		repeat (12) @(posedge clock);
		rst_b <= 1'b1;
		#1 chk(frame_freq, 16'h0007);
		chk({host_may_transfer, addr_increment, display_on, pump_enable, init_pending,
			slope_d_coeff, drivers_ground, mux_1_18}, 16'h0123);
		chk({comp_enable, filter_enable, measure_enable, slope_a_coeff, slope_b_coeff,
			slope_c_coeff}, 16'h0000);
		chk({inversion_mode, segment_reverse, pump_mult, vlcd_value}, 16'h0000);
		tend(1);
		for (i = 0; i < 100 && host_may_transfer !== 1'b1; i = i + 1)
			@(posedge clock);
		#1 chk(host_may_transfer, 16'h0001);
		if (host_may_transfer !== 1'b1)
			stop_test;
		h.send(2'h3, 8'h07, 1'b0);
		#1 chk(measure_enable, 16'h0000);
		h.send(2'h1, 8'h3A, 1'b0);
		#1 chk({init_pending, ram_addr}, 16'h0000);
		tend(2);
		for (i = 0; i < 8; i = i + 1) begin
			h.send(2'h3, i[7:0], 1'b0);
			#1 chk({comp_enable, filter_enable, measure_enable}, i[2:0]);
		end
		h.send(2'h3, 8'h00, 1'b1);
		#1 chk({comp_enable, filter_enable, measure_enable}, 16'h0007);
		for (i = 1; i < 5; i = i + 1)
			h.send(2'h3, {i[4:0], ~i[2:0]}, 1'b0);
		#1 chk({slope_a_coeff, slope_b_coeff, slope_c_coeff, slope_d_coeff}, 16'h0D63);
		tend(3);
		h.send(2'h3, 8'h05, 1'b0);
		smp(8'h5C);
		chk({temperature_value, comp_temperature}, 16'h5C5C);
		rd;
		chk({temp_rd_valid, temp_rd_refused, temperature_value}, 16'h025C);
		h.send(2'h3, 8'h04, 1'b0);
		smp(8'h11);
		rd;
		chk({temp_rd_valid, temp_rd_refused, temperature_value}, 16'h015C);
		h.send(2'h3, 8'h03, 1'b0);
		smp(8'h40);
		@(posedge clock);
		#1 chk({temperature_value, comp_temperature}, 16'h4040);
		smp(8'h48);
		@(posedge clock);
		#1 chk({temperature_value, comp_temperature}, 16'h4141);
		tend(4);
		@(posedge clock) pump_ready <= 1'b1;
		h.send(2'h3, 8'h07, 1'b0);
		h.bring_up(3);
		#1 chk({display_on, pump_enable, pump_run, drivers_ground, ram_addr}, 16'hE003);
		chk(comp_active, 16'h0001);
		h.send(2'h1, 8'h3A, 1'b0);
		#1 chk({display_on, pump_enable, drivers_ground, mux_1_18, comp_enable,
			filter_enable, measure_enable}, 16'h0018);
		chk(ram_addr, 16'h0000);
		chk(comp_active, 16'h0000);
		tend(5);
		h.send(2'h3, 8'h0D, 1'b0);
		h.send(2'h2, 8'h83, 1'b0);
		h.send(2'h2, 8'h28, 1'b0);
		h.send(2'h2, 8'h42, 1'b0);
		h.send(2'h2, 8'h06, 1'b0);
		h.send(2'h3, 8'hA5, 1'b0);
		h.send(2'h3, 8'h93, 1'b0);
		h.send(2'h3, 8'h82, 1'b0);
		#1 chk({slope_a_coeff, frame_freq}, 16'h00A3);
		chk({addr_increment, inversion_mode, segment_reverse, pump_mult,
			vlcd_value}, 16'h2C53);
		pins(1'b0, 1'b0);
		pins(1'b1, 1'b0);
		chk({init_pending, slope_a_coeff, frame_freq}, 16'h0107);
		chk({addr_increment, inversion_mode, segment_reverse, pump_mult,
			vlcd_value}, 16'h8000);
		h.send(2'h1, 8'h3A, 1'b0);
		tend(6);
		pins(1'b1, 1'b1);
		chk({circuits_on, drivers_ground}, 16'h0001);
		h.send(2'h3, 8'h01, 1'b0);
		#1 chk(measure_enable, 16'h0000);
		pins(1'b1, 1'b0);
		chk(circuits_on, 16'h0001);
		h.send(2'h3, 8'h01, 1'b0);
		#1 chk(measure_enable, 16'h0001);
		tend(7);
		stop_test;
	end
endmodule

/* File: rtl/lcd_tc_regs.vh */
// Command codes, field positions, defaults and timing for the display control block.
`ifndef LCD_TC_REGS_VH
`define LCD_TC_REGS_VH

// ==========================================================
// Register select codes
`define RS_DISPLAY 2'h2
`define RS_PUMP_TEMP 2'h3
`define RS_INIT 2'h1

// ==========================================================
// Command prefixes
`define INIT_BYTE 8'h3A
`define PFX_TEMP_CTRL 5'h00
`define PFX_SLOPE_BASE 5'h01
`define PFX_PUMP_CTRL 5'h10
`define PFX_VLCD_MSB 3'h5
`define PFX_VLCD_LSB 4'h9
`define PFX_ENTRY_MODE 6'h0A
`define PFX_INVERSION 5'h08
`define PFX_FRAME_FREQ 3'h4
`define PFX_DISP_CTRL 5'h04
`define PFX_DISP_CFG 6'h01

// ==========================================================
// Field positions
`define BIT_COMP_EN 2
`define BIT_FILTER_EN 1
`define BIT_MEASURE_EN 0
`define BIT_PUMP_EN 2
`define BIT_DISPLAY_ON 2
`define BIT_ADDR_INC 1
`define BIT_SEG_REVERSE 1

// ==========================================================
// Reset values
`define RST_TEMP_CTRL 3'h0
`define RST_SLOPE 3'h0
`define RST_PUMP_MULT 2'h0
`define RST_VLCD 9'h000
`define RST_INVERSION 3'h0
`define RST_FRAME_FREQ 5'h07
`define RST_ADDR_INC 1'h1
`define RST_ADDR 12'h000

// ==========================================================
// Timing
`define CLOCK_PERIOD_NS 50
`define POWERON_WAIT_NS 1000000
`define FILTER_SHIFT 3

`endif

/* File: rtl/lcd_temp_comp_ctrl_and_init.v */
// Command decoder for temperature compensation, start-up and reset of the display driver.
`timescale 1ns/1ps
`include "lcd_tc_regs.vh"
module lcd_temp_comp_ctrl_and_init #(
	parameter POWERON_CYCLES = (`POWERON_WAIT_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS
) (
	input wire clock,
	input wire rst_b,
	input wire reset_pin_b,
	input wire power_down_pin,
	input wire cmd_valid,
	input wire cmd_rw,
	input wire [1:0] cmd_rs,
	input wire [7:0] cmd_data,
	input wire ram_step,
	input wire temp_sample_valid,
	input wire [7:0] temp_sample,
	input wire temp_rd_req,
	input wire pump_ready,
	output wire cmd_accept,
	output wire init_pending,
	output wire host_may_transfer,
	output wire comp_enable,
	output wire filter_enable,
	output wire measure_enable,
	output wire [2:0] slope_a_coeff,
	output wire [2:0] slope_b_coeff,
	output wire [2:0] slope_c_coeff,
	output wire [2:0] slope_d_coeff,
	output wire [7:0] temperature_value,
	output wire temp_rd_valid,
	output wire temp_rd_refused,
	output wire [7:0] comp_temperature,
	output wire comp_active,
	output wire drivers_ground,
	output wire mux_1_18,
	output wire [11:0] ram_addr,
	output wire addr_increment,
	output wire [2:0] inversion_mode,
	output wire [4:0] frame_freq,
	output wire display_on,
	output wire segment_reverse,
	output wire pump_enable,
	output wire [1:0] pump_mult,
	output wire [8:0] vlcd_value,
	output wire pump_run,
	output wire circuits_on
);

	// ==========================================================
	// Decode helpers
	function prefix5;
		input [7:0] data;
		input [4:0] pfx;
		prefix5 = (data[7:3] == pfx);
	endfunction
	function prefix6;
		input [7:0] data;
		input [5:0] pfx;
		prefix6 = (data[7:2] == pfx);
	endfunction

	// ==========================================================
	// Pin synchronisers
	// Both pins are asynchronous to the clock, so each passes two flops first.
	reg rst_pin_meta_r, rst_pin_sync_r, pd_meta_r, pd_sync_r;
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rst_pin_meta_r <= 1'b0;
			rst_pin_sync_r <= 1'b0;
			pd_meta_r <= 1'b0;
			pd_sync_r <= 1'b0;
		end else begin
			rst_pin_meta_r <= reset_pin_b;
			rst_pin_sync_r <= rst_pin_meta_r;
			pd_meta_r <= power_down_pin;
			pd_sync_r <= pd_meta_r;
		end
	end
	wire pin_reset = ~rst_pin_sync_r;
	wire powered = ~pd_sync_r;

	// ==========================================================
	// Power-on wait
	reg [15:0] wait_cnt_r;
	reg wait_done_r;
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wait_cnt_r <= 16'h0000;
			wait_done_r <= 1'b0;
		end else if (!wait_done_r) begin
			if (wait_cnt_r >= POWERON_CYCLES[15:0] - 16'h0001)
				wait_done_r <= 1'b1;
			else
				wait_cnt_r <= wait_cnt_r + 16'h0001;
		end
	end
	assign host_may_transfer = wait_done_r;

	// ==========================================================
	// Command decode
	wire wr_ok = cmd_valid & ~cmd_rw & powered & ~pin_reset;
	wire is_init = wr_ok & (cmd_rs == `RS_INIT) & (cmd_data == `INIT_BYTE);
	reg init_pending_r;
	// first command
	// Until the first initialisation, other commands are dropped on purpose.
	wire wr_cmd = wr_ok & ~init_pending_r & ~is_init;
	wire rs_pt = wr_cmd & (cmd_rs == `RS_PUMP_TEMP);
	wire rs_dp = wr_cmd & (cmd_rs == `RS_DISPLAY);
	wire hit_temp = rs_pt & prefix5(cmd_data, `PFX_TEMP_CTRL);
	wire hit_pump = rs_pt & prefix5(cmd_data, `PFX_PUMP_CTRL);
	wire hit_vmsb = rs_pt & (cmd_data[7:5] == `PFX_VLCD_MSB);
	wire hit_vlsb = rs_pt & (cmd_data[7:4] == `PFX_VLCD_LSB);
	wire hit_entry = rs_dp & prefix6(cmd_data, `PFX_ENTRY_MODE);
	wire hit_inv = rs_dp & prefix5(cmd_data, `PFX_INVERSION);
	wire hit_ff = rs_dp & (cmd_data[7:5] == `PFX_FRAME_FREQ);
	wire hit_dctl = rs_dp & prefix5(cmd_data, `PFX_DISP_CTRL);
	wire hit_dcfg = rs_dp & prefix6(cmd_data, `PFX_DISP_CFG);
	assign cmd_accept = is_init | wr_cmd;
	wire restore = pin_reset | is_init;
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			init_pending_r <= 1'b1;
		else if (pin_reset)
			init_pending_r <= 1'b1;
		else if (is_init)
			init_pending_r <= 1'b0;
	end
	assign init_pending = init_pending_r;

	// ==========================================================
	// Temperature control register
	reg [2:0] temp_ctrl_r;
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			temp_ctrl_r <= `RST_TEMP_CTRL;
		else if (restore)
			temp_ctrl_r <= `RST_TEMP_CTRL;
		else if (hit_temp)
			temp_ctrl_r <= cmd_data[2:0];
	end
	assign comp_enable = temp_ctrl_r[`BIT_COMP_EN];
	assign filter_enable = temp_ctrl_r[`BIT_FILTER_EN];
	assign measure_enable = temp_ctrl_r[`BIT_MEASURE_EN];

	// ==========================================================
	// Slope coefficients
	wire [2:0] slope_w [0:3];
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : slope_gen
			localparam [31:0] SLOPE_PFX = `PFX_SLOPE_BASE + gi;
			reg [2:0] coeff_r;
			always @(posedge clock or negedge rst_b) begin
				if (!rst_b)
					coeff_r <= `RST_SLOPE;
				else if (restore)
					coeff_r <= `RST_SLOPE;
				else if (rs_pt && (cmd_data[7:3] == SLOPE_PFX[4:0]))
					coeff_r <= cmd_data[2:0];
			end
			assign slope_w[gi] = coeff_r;
		end
	endgenerate
	assign slope_a_coeff = slope_w[0];
	assign slope_b_coeff = slope_w[1];
	assign slope_c_coeff = slope_w[2];
	assign slope_d_coeff = slope_w[3];

	// ==========================================================
	// Temperature measurement and readout
	wire take_sample = temp_sample_valid & measure_enable & powered;
	wire [7:0] filt_w;
	reg [7:0] temp_val_r, comp_temp_r;
	reg rd_valid_r, rd_refused_r;
	temp_filter u_filter (
		.clock(clock),
		.rst_b(rst_b),
		.clear(restore | ~filter_enable),
		.sample_valid(take_sample),
		.sample(temp_sample),
		.filtered(filt_w)
	);
	// raw bypass
	// With the filter off the raw sample is taken the same cycle it arrives.
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			temp_val_r <= 8'h00;
			comp_temp_r <= 8'h00;
		end else if (restore) begin
			temp_val_r <= 8'h00;
			comp_temp_r <= 8'h00;
		end else if (filter_enable) begin
			temp_val_r <= filt_w;
			comp_temp_r <= filt_w;
		end else if (take_sample) begin
			temp_val_r <= temp_sample;
			comp_temp_r <= temp_sample;
		end
	end
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rd_valid_r <= 1'b0;
			rd_refused_r <= 1'b0;
		end else begin
			rd_valid_r <= temp_rd_req & measure_enable & powered;
			rd_refused_r <= temp_rd_req & ~(measure_enable & powered);
		end
	end
	assign temperature_value = temp_val_r;
	assign temp_rd_valid = rd_valid_r;
	assign temp_rd_refused = rd_refused_r;
	assign comp_temperature = comp_temp_r;
	assign comp_active = comp_enable & pump_run;

	// ==========================================================
	// Display and addressing settings
	reg addr_inc_r, disp_on_r, seg_rev_r, mux18_r;
	reg [2:0] inv_r;
	reg [4:0] ff_r;
	reg [11:0] addr_r;
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			addr_inc_r <= `RST_ADDR_INC;
			inv_r <= `RST_INVERSION;
			ff_r <= `RST_FRAME_FREQ;
			disp_on_r <= 1'b0;
			seg_rev_r <= 1'b0;
			mux18_r <= 1'b1;
		end else if (restore) begin
			addr_inc_r <= `RST_ADDR_INC;
			inv_r <= `RST_INVERSION;
			ff_r <= `RST_FRAME_FREQ;
			disp_on_r <= 1'b0;
			seg_rev_r <= 1'b0;
			mux18_r <= 1'b1;
		end else begin
			if (hit_entry)
				addr_inc_r <= cmd_data[`BIT_ADDR_INC];
			if (hit_inv)
				inv_r <= cmd_data[2:0];
			if (hit_ff)
				ff_r <= cmd_data[4:0];
			if (hit_dctl)
				disp_on_r <= cmd_data[`BIT_DISPLAY_ON];
			if (hit_dcfg)
				seg_rev_r <= cmd_data[`BIT_SEG_REVERSE];
		end
	end
	// counter clear
	// The counter is command state; the RAM behind it is never touched here.
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			addr_r <= `RST_ADDR;
		else if (restore)
			addr_r <= `RST_ADDR;
		else if (ram_step && powered && !init_pending_r)
			addr_r <= addr_inc_r ? addr_r + 12'h001 : addr_r - 12'h001;
	end
	assign addr_increment = addr_inc_r;
	assign inversion_mode = inv_r;
	assign frame_freq = ff_r;
	assign display_on = disp_on_r;
	assign segment_reverse = seg_rev_r;
	assign mux_1_18 = mux18_r;
	assign ram_addr = addr_r;
	assign drivers_ground = ~disp_on_r | ~powered | init_pending_r;

	// ==========================================================
	// Charge pump and supply settings
	reg pump_en_r;
	reg [1:0] pump_mult_r;
	reg [8:0] vlcd_r;
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			pump_en_r <= 1'b0;
			pump_mult_r <= `RST_PUMP_MULT;
			vlcd_r <= `RST_VLCD;
		end else if (restore) begin
			pump_en_r <= 1'b0;
			pump_mult_r <= `RST_PUMP_MULT;
			vlcd_r <= `RST_VLCD;
		end else begin
			if (hit_pump) begin
				pump_en_r <= cmd_data[`BIT_PUMP_EN];
				pump_mult_r <= cmd_data[1:0];
			end
			if (hit_vmsb)
				vlcd_r[8:4] <= cmd_data[4:0];
			if (hit_vlsb)
				vlcd_r[3:0] <= cmd_data[3:0];
		end
	end
	assign pump_enable = pump_en_r;
	assign pump_mult = pump_mult_r;
	assign vlcd_value = vlcd_r;
	assign pump_run = pump_en_r & powered;
	assign circuits_on = powered;
	// pump before display
	// The device does not hold the display off; pump_ready is for the host only.
	wire unused_pump_ready = pump_ready;
endmodule

/* File: rtl/temp_filter.v */
// Digital low-pass filter on the measured temperature samples.
`timescale 1ns/1ps
module temp_filter (
	input wire clock,
	input wire rst_b,
	input wire clear,
	input wire sample_valid,
	input wire [7:0] sample,
	output wire [7:0] filtered
);
`include "lcd_tc_regs.vh"

	// Extra fraction bits keep small steps from being lost in the shift.
	reg [10:0] acc_r;
	wire [11:0] sum_w;
	wire [10:0] acc_nxt;
	reg primed_r;

	assign sum_w = {1'b0, acc_r} + {4'h0, sample} - {4'h0, acc_r[10:3]};
	assign acc_nxt = primed_r ? sum_w[10:0] : {sample, 3'h0};
	assign filtered = acc_r[10:3];

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			acc_r <= 11'h000;
			primed_r <= 1'b0;
		end else if (clear) begin
			acc_r <= 11'h000;
			primed_r <= 1'b0;
		end else if (sample_valid) begin
			acc_r <= acc_nxt;
			primed_r <= 1'b1;
		end
	end
endmodule
